// ---- include/ped_pkg.sv ----
// shared constants and types for the port edge interrupt detector
package ped_pkg;
    localparam int          PED_NPIN        = 8;
    localparam int          PED_ADDR_W      = 16;
    // printed offsets are not word aligned: they are indices, byte address = 4 * index
    localparam logic [15:0] PED_IDX_EDGE_LO = 16'hf024;
    localparam logic [15:0] PED_IDX_EDGE_HI = 16'hf025;
    localparam logic [15:0] PED_IDX_SAMPLE  = 16'hf026;
    localparam logic [15:0] PED_IDX_STATUS  = 16'hf027;
    localparam logic [15:0] PED_IDX_MASK    = 16'hf028;
    localparam logic [7:0]  PED_CFG_RESET   = 8'h00;
    // bit 3 has no pin
    localparam logic [7:0]  PED_PIN_MAP     = 8'hf7;
    localparam int          PED_SAMPLE_HZ   = 16000;
    localparam int          PED_CLK_HZ      = 250000000;
    localparam int          PED_SAMPLE_DIV  = PED_CLK_HZ / PED_SAMPLE_HZ;
    typedef enum logic [1:0] {
        PED_MODE_OFF,
        PED_MODE_FALL,
        PED_MODE_RISE,
        PED_MODE_BOTH
    } ped_mode_t;
endpackage

// ---- include/ped_cfg_if.sv ----
// configuration bundle from the register file to the edge detector
interface ped_cfg_if;
    import ped_pkg::*;
    logic [7:0] edge_lo;
    logic [7:0] edge_hi;
    logic [7:0] sample_en;
    logic       stop_mode;
    logic       sample_tick;
    logic [7:0] edge_evt;
    modport regs (output edge_lo, output edge_hi, output sample_en, output stop_mode,
                  output sample_tick, input edge_evt);
    modport det  (input edge_lo, input edge_hi, input sample_en, input stop_mode,
                  input sample_tick, output edge_evt);
endinterface

// ---- rtl/ped_tick_div.sv ----
// divider making the low speed sampling tick
module ped_tick_div #(
    parameter int DIV = ped_pkg::PED_SAMPLE_DIV
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic halt,
    output logic      tick
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] cnt_q;
    logic          wrap;
    assign wrap = (cnt_q == CW'(DIV - 1));
    // counter freezes while halted so no tick escapes in stop mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            tick <= wrap & ~halt;
            if (!halt) begin
                cnt_q <= wrap ? '0 : cnt_q + CW'(1);
            end
        end
    end
endmodule

// ---- rtl/ped_detect.sv ----
// per pin synchroniser, optional sampling and edge detection
module ped_detect
    import ped_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic [7:0] pin_in,
    ped_cfg_if.det      cfg
);
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [7:0] smp_q;
    logic [7:0] prev_q;
    logic [7:0] cur;
    logic [7:0] evt_q;
    // two stage synchroniser, first stage read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end
    genvar i;
    generate
        for (i = 0; i < PED_NPIN; i++) begin : g_pin
            ped_mode_t mode;
            logic      rise;
            logic      fall;
            assign mode = ped_mode_t'({cfg.edge_hi[i], cfg.edge_lo[i]});
            // sampled copy holds between ticks; tick is dead in stop mode
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    smp_q[i] <= 1'b0;
                end else if (cfg.sample_tick && !cfg.stop_mode) begin
                    smp_q[i] <= sync2_q[i];
                end
            end
            assign cur[i] = cfg.sample_en[i] ? smp_q[i] : sync2_q[i];
            assign rise   = cur[i] & ~prev_q[i];
            assign fall   = ~cur[i] & prev_q[i];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    prev_q[i] <= 1'b0;
                    evt_q[i]  <= 1'b0;
                end else begin
                    prev_q[i] <= cur[i];
                    evt_q[i]  <= PED_PIN_MAP[i] & (
                        (mode == PED_MODE_FALL && fall) ||
                        (mode == PED_MODE_RISE && rise) ||
                        (mode == PED_MODE_BOTH && (rise || fall)));
                end
            end
        end
    endgenerate
    assign cfg.edge_evt = evt_q;
endmodule

// ---- rtl/ped_top.sv ----
// Function
// - two config bits form per pin mode
// - port a bits 0-2, port b 4-7
// - sampling bit picks raw or sampled input
// - no sampling during stop mode
// - selected edge raises that pin's request
// - seven lines, line three absent
// - config registers 8 bit, reset zero
module ped_top
    import ped_pkg::*;
#(
    parameter int SAMPLE_DIV = PED_SAMPLE_DIV
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  port_a_pin,
    input  wire logic [3:0]  port_b_pin,
    input  wire logic        stop_mode,
    output logic      [2:0]  port_a_pin_irq,
    output logic      [3:0]  port_b_pin_irq,
    output logic             irq
);
    ped_cfg_if cfg ();
    logic [7:0]  edge_lo_q;
    logic [7:0]  edge_hi_q;
    logic [7:0]  sample_q;
    logic [7:0]  status_q;
    logic [7:0]  mask_q;
    logic        stop_s1_q;
    logic        stop_s2_q;
    logic [15:0] idx;
    logic        wr;
    logic        rd;
    logic        hit_lo;
    logic        hit_hi;
    logic        hit_smp;
    logic        hit_st;
    logic        hit_mk;
    logic        mapped;
    logic [7:0]  rsel;
    logic [7:0]  pins;
    logic [7:0]  clr;
    logic        tick;

    // address decode on word index
    assign idx     = paddr[17:2];
    assign wr      = psel & penable & pwrite;
    assign rd      = psel & penable & ~pwrite;
    assign hit_lo  = (idx == PED_IDX_EDGE_LO);
    assign hit_hi  = (idx == PED_IDX_EDGE_HI);
    assign hit_smp = (idx == PED_IDX_SAMPLE);
    assign hit_st  = (idx == PED_IDX_STATUS);
    assign hit_mk  = (idx == PED_IDX_MASK);
    assign mapped  = hit_lo | hit_hi | hit_smp | hit_st | hit_mk;
    assign rsel    = hit_lo  ? edge_lo_q :
                     hit_hi  ? edge_hi_q :
                     hit_smp ? sample_q  :
                     hit_st  ? status_q  :
                     hit_mk  ? mask_q    : 8'h00;
    assign clr     = (wr && hit_st) ? pwdata[7:0] : 8'h00;
    assign pins    = {port_b_pin, 1'b0, port_a_pin};

    // stop request is from outside, synchronise before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_s1_q <= 1'b0;
            stop_s2_q <= 1'b0;
        end else begin
            stop_s1_q <= stop_mode;
            stop_s2_q <= stop_s1_q;
        end
    end

    // configuration registers, bit 3 kept as plain storage except in the mask, where a write forces it low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_lo_q <= PED_CFG_RESET;
            edge_hi_q <= PED_CFG_RESET;
            sample_q  <= PED_CFG_RESET;
            mask_q    <= PED_CFG_RESET;
        end else if (wr) begin
            if (hit_lo)  edge_lo_q <= pwdata[7:0];
            if (hit_hi)  edge_hi_q <= pwdata[7:0];
            if (hit_smp) sample_q  <= pwdata[7:0];
            if (hit_mk)  mask_q    <= pwdata[7:0] & PED_PIN_MAP;
        end
    end

    // sticky status: a new edge wins over a same cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 8'h00;
        end else begin
            status_q <= (status_q & ~clr) | cfg.edge_evt;
        end
    end

    // apb answer registered, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel && !penable && !pwrite) ? {24'h000000, rsel} : 32'h0000_0000;
        end
    end

    // per pin request pulses and masked level interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_pin_irq <= 3'h0;
            port_b_pin_irq <= 4'h0;
            irq            <= 1'b0;
        end else begin
            port_a_pin_irq <= cfg.edge_evt[2:0];
            port_b_pin_irq <= cfg.edge_evt[7:4];
            irq            <= |(((status_q & ~clr) | cfg.edge_evt) & mask_q);
        end
    end

    assign cfg.edge_lo   = edge_lo_q;
    assign cfg.edge_hi   = edge_hi_q;
    assign cfg.sample_en = sample_q;
    assign cfg.stop_mode = stop_s2_q;
    assign cfg.sample_tick = tick;

    ped_tick_div #(.DIV(SAMPLE_DIV)) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .halt    (stop_s2_q),
        .tick    (tick)
    );

    ped_detect u_det (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (pins),
        .cfg     (cfg)
    );

    // read data of edge_select_low follows the setup cycle
    property p_read_data;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_lo) |=> (prdata[7:0] == edge_lo_q);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("edge_select_low read mismatch");

    // read data of edge_select_high follows the setup cycle
    property p_read_hi;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_hi) |=> (prdata[7:0] == edge_hi_q);
    endproperty
    a_read_hi: assert property (p_read_hi)
        else $error("edge_select_high read mismatch");

    // read data of sampling_select follows the setup cycle
    property p_read_smp;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_smp) |=> (prdata[7:0] == sample_q);
    endproperty
    a_read_smp: assert property (p_read_smp)
        else $error("sampling_select read mismatch");

    // a write to sampling_select lands whole
    property p_cfg_write;
        @(posedge pclk) disable iff (!presetn)
        (wr && hit_smp) |=> (sample_q == $past(pwdata[7:0]));
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("sampling_select write lost");

    // no pin behind bit 3, so its status never sets
    property p_no_pin3;
        @(posedge pclk) disable iff (!presetn)
        status_q[3] == 1'b0;
    endproperty
    a_no_pin3: assert property (p_no_pin3)
        else $error("status bit 3 set");

    // mask bit 3 is forced low on write
    property p_mask_pin3;
        @(posedge pclk) disable iff (!presetn)
        mask_q[3] == 1'b0;
    endproperty
    a_mask_pin3: assert property (p_mask_pin3)
        else $error("mask bit 3 set");

    // detector never reports the absent line
    property p_evt_pin3;
        @(posedge pclk) disable iff (!presetn)
        cfg.edge_evt[3] == 1'b0;
    endproperty
    a_evt_pin3: assert property (p_evt_pin3)
        else $error("event on absent line");

    // disabled pin stays quiet, port a side
    property p_off_quiet;
        @(posedge pclk) disable iff (!presetn)
        (edge_lo_q[0] == 1'b0 && edge_hi_q[0] == 1'b0) |=> !port_a_pin_irq[0];
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("irq from disabled pin");

    // disabled pin stays quiet, port b side
    property p_off_quiet_b;
        @(posedge pclk) disable iff (!presetn)
        (edge_lo_q[7] == 1'b0 && edge_hi_q[7] == 1'b0) |=> !port_b_pin_irq[3];
    endproperty
    a_off_quiet_b: assert property (p_off_quiet_b)
        else $error("irq from disabled pin");

    // a request is a single cycle pulse, port a side
    property p_pulse_one;
        @(posedge pclk) disable iff (!presetn)
        port_a_pin_irq[0] |=> !port_a_pin_irq[0];
    endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("request not one cycle");

    // a request is a single cycle pulse, port b side
    property p_pulse_one_b;
        @(posedge pclk) disable iff (!presetn)
        port_b_pin_irq[3] |=> !port_b_pin_irq[3];
    endproperty
    a_pulse_one_b: assert property (p_pulse_one_b)
        else $error("request not one cycle");

    // status rises together with the port b request
    property p_irq_sticky;
        @(posedge pclk) disable iff (!presetn)
        port_b_pin_irq[0] |-> status_q[4];
    endproperty
    a_irq_sticky: assert property (p_irq_sticky)
        else $error("event not latched");

    // status rises together with the port a request
    property p_sticky_a;
        @(posedge pclk) disable iff (!presetn)
        port_a_pin_irq[2] |-> status_q[2];
    endproperty
    a_sticky_a: assert property (p_sticky_a)
        else $error("event not latched");

    // a set status bit holds until a one is written to it
    property p_status_hold;
        @(posedge pclk) disable iff (!presetn)
        (status_q[7] && !(wr && hit_st && pwdata[7])) |=> status_q[7];
    endproperty
    a_status_hold: assert property (p_status_hold)
        else $error("status bit lost");

    // halted divider gives no tick
    property p_stop_tick;
        @(posedge pclk) disable iff (!presetn)
        stop_s2_q |=> !tick;
    endproperty
    a_stop_tick: assert property (p_stop_tick)
        else $error("tick in stop mode");

    // zero wait: ready in the access cycle
    property p_apb_ready;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("no ready after setup");

    // ready stands one cycle only
    property p_ready_one;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_ready_one: assert property (p_ready_one)
        else $error("ready held too long");

    // unmapped index answers with an error
    property p_err_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !mapped) |=> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("no error on unmapped index");

    // level interrupt follows unmasked status
    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        ((status_q & mask_q) != 8'h00 && !(wr && hit_st)) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("irq low with unmasked status");

    // no unmasked status and no event means no interrupt
    property p_irq_quiet;
        @(posedge pclk) disable iff (!presetn)
        ((status_q & mask_q) == 8'h00 && cfg.edge_evt == 8'h00) |=> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("irq high without cause");

    // rd is kept for this read data check
    property p_rd_zero;
        @(posedge pclk) disable iff (!presetn)
        (rd && !mapped) |-> prdata == 32'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("unmapped read not zero");

    // registers are 8 bit, upper read bits stay low
    property p_upper_zero;
        @(posedge pclk) disable iff (!presetn)
        prdata[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read data not zero");

    // read data is zero outside a read answer
    property p_idle_data;
        @(posedge pclk) disable iff (!presetn)
        !(psel && !penable && !pwrite) |=> prdata == 32'h0;
    endproperty
    a_idle_data: assert property (p_idle_data)
        else $error("read data outside a read");

    // main scenarios to be reached
    c_rise: cover property (@(posedge pclk) disable iff (!presetn)
        edge_hi_q[0] && !edge_lo_q[0] && port_a_pin_irq[0]);
    c_both: cover property (@(posedge pclk) disable iff (!presetn)
        edge_hi_q[4] && edge_lo_q[4] && port_b_pin_irq[0]);
    c_sampled: cover property (@(posedge pclk) disable iff (!presetn)
        sample_q[1] && port_a_pin_irq[1]);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule

// ---- tb/ped_pin_src.sv ----
// external signal source driving the port interrupt pins
module ped_pin_src (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [6:0] level,
    output logic      [2:0] port_a_pin,
    output logic      [3:0] port_b_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins only ever act as inputs, so this source is their sole driver
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_pin <= 3'h0;
            port_b_pin <= 4'h0;
        end else begin
            port_a_pin <= level[2:0];
            port_b_pin <= level[6:3];
        end
    end
endmodule

// ---- tb/ped_top_tb.sv ----
// self checking bench for the port edge interrupt detector
module ped_top_tb import ped_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [6:0]  level = 7'h0;
    logic        stop_mode = 1'b0;
    logic [2:0]  pa;
    logic [3:0]  pb;
    logic [2:0]  pa_irq;
    logic [3:0]  pb_irq;
    logic        irq;
    logic [31:0] rd;
    logic        er;
    logic [6:0]  seen;
    logic [6:0]  exp_r;
    logic [6:0]  exp_f;
    int          n_pulse;
    int          err_total = 0;
    int          n_compared = 0;
    int          cyc = 0;
    // four uniform modes, then a mix of per-pin modes
    logic [7:0]  lo_t[5] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'ha5};
    logic [7:0]  hi_t[5] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'hc6};

    always #2 pclk = ~pclk;

    ped_top #(.SAMPLE_DIV(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_a_pin(pa),
        .port_b_pin(pb), .stop_mode(stop_mode), .port_a_pin_irq(pa_irq),
        .port_b_pin_irq(pb_irq), .irq(irq));
    ped_pin_src src (.pclk(pclk), .presetn(presetn), .level(level),
        .port_a_pin(pa), .port_b_pin(pb));

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [15:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 32'h0);
        check(what, {24'h0, exp}, rd);
    endtask

    // collect request pulses over n cycles
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge pclk);
            seen = seen | {pb_irq, pa_irq};
            n_pulse += $countones({pb_irq, pa_irq});
        end
    endtask

    // hang guard, well above the expected run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("edge_select_low", PED_IDX_EDGE_LO, 8'h00);
        rd_chk("edge_select_high", PED_IDX_EDGE_HI, 8'h00);
        rd_chk("sampling_select", PED_IDX_SAMPLE, 8'h00);
        apb(1'b1, PED_IDX_EDGE_LO, 32'h1234_563c);
        apb(1'b1, PED_IDX_EDGE_HI, 32'hffff_ffc3);
        apb(1'b1, PED_IDX_SAMPLE, 32'h0000_005a);
        rd_chk("edge_select_low", PED_IDX_EDGE_LO, 8'h3c);
        rd_chk("edge_select_high", PED_IDX_EDGE_HI, 8'hc3);
        rd_chk("sampling_select", PED_IDX_SAMPLE, 8'h5a);
        apb(1'b1, PED_IDX_SAMPLE, 32'h0);
        apb(1'b0, 16'hf030, 32'h0);
        check("unmapped error", 32'h1, 32'(er));
        check("unmapped data", 32'h0, rd);
        for (int i = 0; i < 5; i++) begin
            exp_r = {hi_t[i][7:4], hi_t[i][2:0]};
            exp_f = {lo_t[i][7:4], lo_t[i][2:0]};
            apb(1'b1, PED_IDX_EDGE_LO, {24'h0, lo_t[i]});
            apb(1'b1, PED_IDX_EDGE_HI, {24'h0, hi_t[i]});
            apb(1'b1, PED_IDX_STATUS, 32'hff);
            seen = 7'h0;
            n_pulse = 0;
            level <= 7'h7f;
            pulses(12);
            check("rise requests", 32'(seen), 32'(exp_r));
            seen = 7'h0;
            level <= 7'h00;
            pulses(12);
            check("fall requests", 32'(seen), 32'(exp_f));
            check("pulse count", 32'(n_pulse), 32'($countones({exp_r, exp_f})));
            rd_chk("status", PED_IDX_STATUS, (lo_t[i] | hi_t[i]) & PED_PIN_MAP);
        end
        // status now e7 from the mixed modes
        check("irq masked", 32'(irq), 32'h0);
        apb(1'b1, PED_IDX_MASK, 32'hff);
        rd_chk("mask", PED_IDX_MASK, 8'hf7);
        check("irq raised", 32'(irq), 32'h1);
        apb(1'b1, PED_IDX_STATUS, 32'h07);
        rd_chk("status cleared", PED_IDX_STATUS, 8'he0);
        apb(1'b1, PED_IDX_MASK, 32'h0f);
        rd_chk("status kept", PED_IDX_STATUS, 8'he0);
        check("irq low", 32'(irq), 32'h0);
        apb(1'b1, PED_IDX_STATUS, 32'hff);
        // sampling picked while disabled, so the switch raises nothing
        apb(1'b1, PED_IDX_EDGE_LO, 32'h0);
        apb(1'b1, PED_IDX_EDGE_HI, 32'h0);
        apb(1'b1, PED_IDX_SAMPLE, 32'hff);
        pulses(20);
        apb(1'b1, PED_IDX_EDGE_HI, 32'hff);
        seen = 7'h0;
        level <= 7'h7f;
        pulses(30);
        check("sampled rise", 32'(seen), 32'h7f);
        stop_mode <= 1'b1;
        pulses(10);
        apb(1'b1, PED_IDX_EDGE_LO, 32'hff);
        seen = 7'h0;
        level <= 7'h00;
        pulses(40);
        check("stopped sampling", 32'(seen), 32'h0);
        stop_mode <= 1'b0;
        pulses(40);
        check("resumed sampling", 32'(seen), 32'h7f);
        stop_test();
    end
endmodule
